// file: rtl/agcfe_log2.sv
// Base-2 logarithm of an unsigned word, integer plus linear fraction
`timescale 1ns/1ps
`default_nettype none
module agcfe_log2
    import agcfe_pkg::*;
#(
    parameter int W = ACC_W
) (
    input  wire logic [W-1:0]     val_i,
    output logic      [LOG_W-1:0] log_o
);

    initial begin
        if (W < LOG_FR + 1 || W > 64) begin
            $error("agcfe_log2: width out of range");
        end
    end

    // Fraction is the mantissa below the leading one, a cheap
    // piecewise linear log with under 0.09 octave error
    always_comb begin
        logic [5:0]   msb;
        logic [W-1:0] norm;
        msb  = 6'h00;
        norm = '0;
        for (int k = 0; k < W; k++) begin
            if (val_i[k]) begin
                msb = 6'(k);
            end
        end
        norm  = val_i << (6'(W - 1) - msb);
        log_o = {msb, norm[W-2 -: LOG_FR]};
    end

endmodule : agcfe_log2
`default_nettype wire

// file: rtl/agcfe_pkg.sv
// Package: constants and types of the gain loop power/error front end
package agcfe_pkg;

    // Stream widths
    localparam int IN_W    = 22;
    localparam int OUT_W   = 16;
    localparam int POW_W   = 46;
    localparam int SCL_MAX = 14;
    localparam int ACC_W   = POW_W + SCL_MAX;
    localparam int LOG_W   = 13;
    localparam int LOG_FR  = 7;
    localparam int RMS_W   = 12;
    localparam int ERR_W   = 14;
    localparam int DEC_W   = 12;
    localparam int AVG_MAX = 4;

    // Full scale amplitude, log2 of 2^21 in 1/64 octave units
    localparam logic [RMS_W-1:0] FS_LOG = 12'h540;

    // Register word offsets inside one channel window
    localparam int CH_SHIFT = 5;
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_AVG    = 3'h1;
    localparam logic [2:0] REG_REQ    = 3'h2;
    localparam logic [2:0] REG_DEC    = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;

    // Control register fields
    localparam int CTRL_BYP  = 0;
    localparam int CTRL_CLIP = 1;
    localparam int CTRL_WL   = 2;
    localparam int CTRL_W    = 5;
    // Average register fields
    localparam int AVG_AVERAGE_MULTIPLE  = 0;
    localparam int AVG_SCALE = 4;
    localparam int AVG_W     = 8;
    // Request level fields
    localparam int REQ_MANT  = 0;
    localparam int REQ_EXP   = 6;
    localparam int REQ_W     = 8;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [AVG_W-1:0]  AVG_RST  = 8'h00;
    localparam logic [REQ_W-1:0]  REQ_RST  = 8'h00;
    localparam logic [DEC_W-1:0]  DEC_RST  = 12'h000;

    typedef struct packed {
        logic signed [IN_W-1:0] i;
        logic signed [IN_W-1:0] q;
    } agcfe_iq_s;

    typedef struct packed {
        logic signed [OUT_W-1:0] i;
        logic signed [OUT_W-1:0] q;
    } agcfe_iq16_s;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [AVG_W-1:0]  avg;
        logic [REQ_W-1:0]  req;
        logic [DEC_W-1:0]  dec;
    } agcfe_cfg_s;

    typedef struct packed {
        logic                           pow_v;
        logic [POW_W-1:0]               pow;
        logic [DEC_W-1:0]               cnt;
        logic [ACC_W-1:0]               acc;
        logic [AVG_MAX-1:0][ACC_W-1:0]  fifo;
        logic                           blk_v;
        logic signed [ERR_W-1:0]        err;
        logic                           err_v;
        agcfe_iq16_s                    dout;
        logic                           dout_v;
    } agcfe_chan_s;

endpackage : agcfe_pkg

// file: rtl/agcfe_top.sv
// Gain loop power measurement, averaging, log RMS and error front end
//
// Notes on behaviour
// - Six independent loops sit between data router and output ports, 96 dB.
// - Each loop reduces 22-bit I/Q to 4,5,6,7,8,10,12 or 16 bits.
// - A 3-bit word-length field per channel control register picks the width.
// - Bypassed loops still truncate the 22-bit input to 16 bits and forward it.
// - Bypass bit at 1 bypasses only that channel's loop.
// - Mode bit 0 selects desired signal level operation.
// - Signal mode measures pre-clip samples; clip mode measures clip residue.
// - Instantaneous power is I squared plus Q squared.
// - Power, not RMS, is averaged over 1 to 16,384 samples.
// - Loop updates once every M samples, M 1..4,096 in a 12-bit register.
// - Averaging length is 1, 2, 3 or 4 times the decimation ratio.
// - Averaging and decimation form a first-order CIC with FIFO storage.
// - Power samples are attenuated before the CIC stage.
// - Attenuation comes from a 4-bit scale field, 0 to 14.
// - Each scale step is a one-bit right shift, 3.01 dB.
// - Base-2 log is taken of each decimated averaged power.
// - Square root is a one-place right shift of the log value.
// - Error is request level minus RMS log, passed to the loop filter.
// - Request level spans 0 down to -23.99 dB in 0.094 dB steps.
// - Request register: 2-bit exponent at 6.02 dB, 6-bit mantissa 0.094 dB.
// - Clip mode bit at 1 makes the request level a target clipping level.
`timescale 1ns/1ps
`default_nettype none
module agcfe_top
    import agcfe_pkg::*;
#(
    parameter int NUM_LOOPS = 6,
    parameter int ADR_W     = 8
) (
    input  wire logic                               clk_i,
    input  wire logic                               rstn_i,
    // Classic Wishbone slave
    input  wire logic                               wb_cyc_i,
    input  wire logic                               wb_stb_i,
    input  wire logic                               wb_we_i,
    input  wire logic [ADR_W-1:0]                   wb_adr_i,
    input  wire logic [3:0]                         wb_sel_i,
    input  wire logic [31:0]                        wb_dat_i,
    output logic      [31:0]                        wb_dat_o,
    output logic                                    wb_ack_o,
    // Sample streams from the data router
    input  wire agcfe_iq_s   [NUM_LOOPS-1:0]        smp_i,
    input  wire logic        [NUM_LOOPS-1:0]        smp_valid_i,
    // Streams to the output ports
    output agcfe_iq16_s      [NUM_LOOPS-1:0]        out_o,
    output logic             [NUM_LOOPS-1:0]        out_valid_o,
    // Error terms to the loop filters
    output logic [NUM_LOOPS-1:0][ERR_W-1:0]         err_o,
    output logic             [NUM_LOOPS-1:0]        err_valid_o
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    initial begin
        if (NUM_LOOPS < 1 || NUM_LOOPS > 8) begin
            $error("agcfe_top: NUM_LOOPS must be 1..8");
        end
        if ((NUM_LOOPS << CH_SHIFT) > (1 << ADR_W)) begin
            $error("agcfe_top: ADR_W too small for all channels");
        end
        if (ADR_W <= CH_SHIFT) begin
            $error("agcfe_top: ADR_W leaves no channel bits");
        end
        // The datapath below leans on these package relations
        if (POW_W < 2 * IN_W + 2) begin
            $error("agcfe_top: POW_W cannot hold I*I+Q*Q");
        end
        if (OUT_W > IN_W) begin
            $error("agcfe_top: OUT_W above IN_W");
        end
        if (ACC_W < POW_W + SCL_MAX) begin
            $error("agcfe_top: ACC_W below CIC growth");
        end
        if (ACC_W > 64) begin
            $error("agcfe_top: ACC_W beyond the log index");
        end
        if (LOG_W != 6 + LOG_FR) begin
            $error("agcfe_top: LOG_W must be 6+LOG_FR");
        end
        if (RMS_W != LOG_W - 1) begin
            $error("agcfe_top: RMS_W must be LOG_W-1");
        end
        if (ERR_W != RMS_W + 2) begin
            $error("agcfe_top: ERR_W must be RMS_W+2");
        end
        if (DEC_W != 12) begin
            $error("agcfe_top: block counter is 12 bits");
        end
        if (AVG_MAX != 4) begin
            $error("agcfe_top: multiple field serves 4 blocks");
        end
        if (CTRL_WL + 3 > CTRL_W) begin
            $error("agcfe_top: word-length field outside ctrl");
        end
        if (AVG_SCALE + 4 > AVG_W) begin
            $error("agcfe_top: scale field outside avg");
        end
        if (REQ_EXP + 2 > REQ_W) begin
            $error("agcfe_top: exponent outside request");
        end
        if (SCL_MAX > 15) begin
            $error("agcfe_top: SCL_MAX beyond 4 bits");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Output width in bits for a word-length code
    function automatic logic [4:0] wl_bits(input logic [2:0] code);
        case (code)
            3'h0:    wl_bits = 5'h04;
            3'h1:    wl_bits = 5'h05;
            3'h2:    wl_bits = 5'h06;
            3'h3:    wl_bits = 5'h07;
            3'h4:    wl_bits = 5'h08;
            3'h5:    wl_bits = 5'h0a;
            3'h6:    wl_bits = 5'h0c;
            default: wl_bits = 5'h10;
        endcase
    endfunction : wl_bits

    // Mask keeping the top bits of a 22-bit word for a word-length code
    function automatic logic [IN_W-1:0] keep_mask(input logic [2:0] code);
        keep_mask = ~({IN_W{1'b1}} >> wl_bits(code));
    endfunction : keep_mask

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        for (int b = 0; b < 4; b++) begin
            lane_merge[8*b +: 8] = sel[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
        end
    endfunction : lane_merge

    ////////////////////////////////////////////////////////////////////////
    // Register file state

    typedef struct packed {
        logic                          ack;
        logic [31:0]                   rdata;
        agcfe_cfg_s [NUM_LOOPS-1:0]    cfg;
    } agcfe_bus_s;

    agcfe_bus_s bus;
    agcfe_bus_s next_bus;

    logic [ADR_W-CH_SHIFT-1:0] bus_ch;
    logic [2:0]                bus_reg;
    logic                      bus_hit;

    assign bus_ch  = wb_adr_i[ADR_W-1:CH_SHIFT];
    assign bus_reg = wb_adr_i[CH_SHIFT-1:2];
    assign bus_hit = (32'(bus_ch) < 32'(NUM_LOOPS));

    // One wait state: ack rises the cycle after the request and the
    // write lands on the edge that the master sees ack
    always_comb begin
        logic [31:0] cur;
        cur      = 32'h0;
        next_bus = bus;
        next_bus.ack = wb_cyc_i && wb_stb_i && !bus.ack;
        if (wb_cyc_i && wb_stb_i && !bus.ack) begin
            next_bus.rdata = 32'h0;
            if (bus_hit && !wb_we_i) begin
                case (bus_reg)
                    REG_CTRL:   next_bus.rdata = 32'(bus.cfg[bus_ch].ctrl);
                    REG_AVG:    next_bus.rdata = 32'(bus.cfg[bus_ch].avg);
                    REG_REQ:    next_bus.rdata = 32'(bus.cfg[bus_ch].req);
                    REG_DEC:    next_bus.rdata = 32'(bus.cfg[bus_ch].dec);
                    REG_STATUS: next_bus.rdata = 32'(err_o[bus_ch]);
                    default:    next_bus.rdata = 32'h0;
                endcase
            end
        end
        if (wb_cyc_i && wb_stb_i && wb_we_i && bus.ack && bus_hit) begin
            case (bus_reg)
                REG_CTRL: begin
                    cur = lane_merge(32'(bus.cfg[bus_ch].ctrl), wb_dat_i,
                                     wb_sel_i);
                    next_bus.cfg[bus_ch].ctrl = cur[CTRL_W-1:0];
                end
                REG_AVG: begin
                    cur = lane_merge(32'(bus.cfg[bus_ch].avg), wb_dat_i,
                                     wb_sel_i);
                    next_bus.cfg[bus_ch].avg = cur[AVG_W-1:0];
                end
                REG_REQ: begin
                    cur = lane_merge(32'(bus.cfg[bus_ch].req), wb_dat_i,
                                     wb_sel_i);
                    next_bus.cfg[bus_ch].req = cur[REQ_W-1:0];
                end
                REG_DEC: begin
                    cur = lane_merge(32'(bus.cfg[bus_ch].dec), wb_dat_i,
                                     wb_sel_i);
                    next_bus.cfg[bus_ch].dec = cur[DEC_W-1:0];
                end
                default: begin
                    cur = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus.ack   <= 1'b0;
            bus.rdata <= 32'h0;
            for (int c = 0; c < NUM_LOOPS; c++) begin
                bus.cfg[c] <= {CTRL_RST, AVG_RST, REQ_RST, DEC_RST};
            end
        end else begin
            bus <= next_bus;
        end
    end

    assign wb_ack_o = bus.ack;
    assign wb_dat_o = bus.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel loops

    for (genvar g = 0; g < NUM_LOOPS; g++) begin : g_loop
        agcfe_chan_s                  st;
        agcfe_chan_s                  next_st;
        agcfe_cfg_s                   cfg;
        logic [IN_W-1:0]              mask;
        logic signed [IN_W:0]         mi;
        logic signed [IN_W:0]         mq;
        logic [3:0]                   scl;
        logic [1:0]                   average_multiple;
        logic [ACC_W-1:0]             avg_sum;
        logic [LOG_W-1:0]             pow_log;
        logic [RMS_W-1:0]             rms_log;
        logic [RMS_W-2:0]             rms_q6;
        logic [REQ_W-1:0]             req_lin;

        assign cfg  = bus.cfg[g];
        assign average_multiple = cfg.avg[AVG_AVERAGE_MULTIPLE +: 2];
        // Scale codes above 14 behave as 14
        assign scl  = (cfg.avg[AVG_SCALE +: 4] > 4'(SCL_MAX)) ?
                      4'(SCL_MAX) : cfg.avg[AVG_SCALE +: 4];
        assign mask = keep_mask(cfg.ctrl[CTRL_WL +: 3]);

        // Measured pair: raw samples or the truncation residue
        always_comb begin
            if (cfg.ctrl[CTRL_CLIP]) begin
                mi = {1'b0, smp_i[g].i & ~mask};
                mq = {1'b0, smp_i[g].q & ~mask};
            end else begin
                mi = {smp_i[g].i[IN_W-1], smp_i[g].i};
                mq = {smp_i[g].q[IN_W-1], smp_i[g].q};
            end
        end

        // Sum of the newest block sums, 1 to 4 of them
        always_comb begin
            avg_sum = '0;
            for (int k = 0; k < AVG_MAX; k++) begin
                if (k <= int'(average_multiple)) begin
                    avg_sum = avg_sum + st.fifo[k];
                end
            end
        end

        agcfe_log2 #(
            .W (ACC_W)
        ) u_log2 (
            .val_i (avg_sum),
            .log_o (pow_log)
        );

        assign rms_log = pow_log[LOG_W-1:1];
        // Root is in 1/128 octave, request and full scale in 1/64, so the
        // last fraction bit goes before the subtraction
        assign rms_q6  = rms_log[RMS_W-1:1];
        assign req_lin = {cfg.req[REQ_EXP +: 2], cfg.req[REQ_MANT +: 6]};

        always_comb begin
            logic signed [2*IN_W+1:0] sq;
            sq      = mi * mi + mq * mq;
            next_st = st;
            next_st.pow_v  = smp_valid_i[g] && !cfg.ctrl[CTRL_BYP];
            next_st.pow    = POW_W'(sq[POW_W-1:0] >> scl);
            next_st.blk_v  = 1'b0;
            next_st.err_v  = 1'b0;
            next_st.dout_v = smp_valid_i[g];
            if (smp_valid_i[g]) begin
                if (cfg.ctrl[CTRL_BYP]) begin
                    next_st.dout.i = smp_i[g].i[IN_W-1 -: OUT_W];
                    next_st.dout.q = smp_i[g].q[IN_W-1 -: OUT_W];
                end else begin
                    next_st.dout.i = OUT_W'((smp_i[g].i & mask) >>
                                            (IN_W - OUT_W));
                    next_st.dout.q = OUT_W'((smp_i[g].q & mask) >>
                                            (IN_W - OUT_W));
                end
            end
            // Integrate and dump, M samples per block
            if (st.pow_v) begin
                // At or above, so lowering M mid-block dumps at once
                if (st.cnt >= cfg.dec) begin
                    next_st.fifo  = {st.fifo[AVG_MAX-2:0],
                                     st.acc + ACC_W'(st.pow)};
                    next_st.acc   = '0;
                    next_st.cnt   = '0;
                    next_st.blk_v = 1'b1;
                end else begin
                    next_st.acc = st.acc + ACC_W'(st.pow);
                    next_st.cnt = st.cnt + 12'h001;
                end
            end
            // Error term once per completed block
            if (st.blk_v) begin
                next_st.err = ERR_W'($signed({2'b00, FS_LOG}) -
                                     $signed({6'h00, req_lin}) -
                                     $signed({3'b000, rms_q6}));
                next_st.err_v = 1'b1;
            end
        end

        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                st <= '0;
            end else begin
                st <= next_st;
            end
        end

        assign out_o[g]       = st.dout;
        assign out_valid_o[g] = st.dout_v;
        assign err_o[g]       = st.err;
        assign err_valid_o[g] = st.err_v;
    end

endmodule : agcfe_top
`default_nettype wire

// file: testbench/agcfe_assertions.sv
// Port checks of the gain loop front end
`timescale 1ns/1ps
`default_nettype none
module agcfe_assertions
    import agcfe_pkg::*;
#(
    parameter int NUM_LOOPS = 6,
    parameter int ADR_W     = 8
) (
    input wire logic                            clk_i,
    input wire logic                            rstn_i,
    input wire logic                            wb_cyc_i,
    input wire logic                            wb_stb_i,
    input wire logic                            wb_we_i,
    input wire logic [ADR_W-1:0]                wb_adr_i,
    input wire logic [3:0]                      wb_sel_i,
    input wire logic [31:0]                     wb_dat_i,
    input wire logic [31:0]                     wb_dat_o,
    input wire logic                            wb_ack_o,
    input wire agcfe_iq_s   [NUM_LOOPS-1:0]     smp_i,
    input wire logic        [NUM_LOOPS-1:0]     smp_valid_i,
    input wire agcfe_iq16_s [NUM_LOOPS-1:0]     out_o,
    input wire logic        [NUM_LOOPS-1:0]     out_valid_o,
    input wire logic [NUM_LOOPS-1:0][ERR_W-1:0] err_o,
    input wire logic        [NUM_LOOPS-1:0]     err_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////////
    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_pulse_a: assert property (wb_req_s |=> ack_pulse_s)
        else $error("ack late or too long");
    ack_origin_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i &&
        (wb_adr_i[ADR_W-1:5] >= NUM_LOOPS || wb_adr_i[4:2] > 3'h4)
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    read_upper_a: assert property (wb_ack_o && !wb_we_i
        |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper read bits set");
    out_follow_a: assert property (out_valid_o == $past(smp_valid_i))
        else $error("output strobe not one cycle after sample");
    out_hold_a: assert property (!out_valid_o[0] |-> $stable(out_o[0]))
        else $error("output moved without strobe");
    err_timing_a: assert property (err_valid_o[0] |->
        $past(smp_valid_i[0], 3))
        else $error("error strobe without sample three cycles back");
    err_hold_a: assert property (!err_valid_o[0] |-> $stable(err_o[0]))
        else $error("error term moved without strobe");
endmodule : agcfe_assertions
`default_nettype wire
bind agcfe_top agcfe_assertions #(.NUM_LOOPS(NUM_LOOPS), .ADR_W(ADR_W))
    agcfe_assertions_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smp_i(smp_i),
    .smp_valid_i(smp_valid_i), .out_o(out_o), .out_valid_o(out_valid_o),
    .err_o(err_o), .err_valid_o(err_valid_o));

// file: testbench/agcfe_router_model.sv
// Upstream router model: one sample per call, garbled data when idle
`timescale 1ns/1ps
`default_nettype none
module agcfe_router_model
    import agcfe_pkg::*;
#(
    parameter int NUM_LOOPS = 6
) (
    input  wire logic                    clk_i,
    output var  agcfe_iq_s [NUM_LOOPS-1:0] smp_o,
    output var  logic [NUM_LOOPS-1:0]    smp_valid_o
);
    initial begin
        smp_o       = '0;
        smp_valid_o = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Valid stands one cycle; the router has no back-pressure to obey
    task automatic send(input int ch, input agcfe_iq_s s);
        @(posedge clk_i);
        smp_o[ch]       <= s;
        smp_valid_o[ch] <= 1'b1;
        @(posedge clk_i);
        smp_valid_o[ch] <= 1'b0;
        // Stale data inverted so the block cannot lean on it
        smp_o[ch]       <= ~s;
    endtask : send
endmodule : agcfe_router_model
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench of the gain loop front end
`timescale 1ns/1ps
`default_nettype none
module testbench
    import agcfe_pkg::*;
;
    localparam int NL = 6;
    localparam logic [21:0] IV = 22'h2d5b6f;
    localparam logic [21:0] QV = 22'h15a5a5;
    logic                     clk, rstn, cyc, stb, we, ack;
    logic [7:0]               adr;
    logic [3:0]               sel;
    logic [31:0]              wdat, rd, rdat;
    agcfe_iq_s   [NL-1:0]     smp;
    agcfe_iq16_s [NL-1:0]     outd;
    logic        [NL-1:0]     smp_v, out_v, err_v;
    logic [NL-1:0][ERR_W-1:0] err;
    int                       fail_count = 0;
    int                       checked = 0;
    int                       cycles = 0;
    int                       err_cnt [NL] = '{default: 0};

    agcfe_top #(.NUM_LOOPS(NL), .ADR_W(8)) agcfe_top_inst (
        .clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rd), .wb_ack_o(ack), .smp_i(smp), .smp_valid_i(smp_v),
        .out_o(outd), .out_valid_o(out_v), .err_o(err), .err_valid_o(err_v));
    agcfe_router_model #(.NUM_LOOPS(NL)) agcfe_router_model_inst (
        .clk_i(clk), .smp_o(smp), .smp_valid_o(smp_v));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        for (int g = 0; g < NL; g++) err_cnt[g] += int'(err_v[g] === 1'b1);
        // Whole run needs about 200 cycles
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset
    // Request held until ack is sampled; no fixed answer time assumed
    task automatic wb(input logic w, input int ch,
                      input logic [2:0] r, input logic [31:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {3'(ch), r, 2'b00};
        wdat <= d;
        sel  <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb
    task automatic rd_chk(input int ch, input logic [2:0] r,
                          input logic [31:0] exp);
        wb(1'b0, ch, r, 32'h0);
        check(rdat, exp);
    endtask : rd_chk
    task automatic put_err(input logic [21:0] i, input logic [13:0] exp);
        int n;
        n = 0;
        agcfe_router_model_inst.send(0, {i, 22'h0});
        while (err_v[0] !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check({31'h0, err_v[0]}, 32'h1);
        check({18'h0, err[0]}, {18'h0, exp});
        @(posedge clk);
    endtask : put_err
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd_chk(0, REG_CTRL, 32'h0);
        rd_chk(0, REG_AVG, 32'h0);
        rd_chk(0, REG_REQ, 32'h0);
        wb(1'b1, 5, REG_REQ, 32'hffff_ffa5);
        rd_chk(5, REG_REQ, 32'ha5);
        wb(1'b1, 5, REG_DEC, 32'hffff_ffff);
        rd_chk(5, REG_DEC, 32'hfff);
        rd_chk(0, REG_DEC, 32'h0);
        wb(1'b1, 6, REG_REQ, 32'h77);
        rd_chk(6, REG_REQ, 32'h0);
        rd_chk(0, 3'h6, 32'h0);
    endtask : t_regs
    task automatic t_width();
        int          w [8] = '{4, 5, 6, 7, 8, 10, 12, 16};
        logic [15:0] m;
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, 0, REG_CTRL, 32'(k) << CTRL_WL);
            m = 16'hffff << (16 - w[k]);
            agcfe_router_model_inst.send(0, {IV, QV});
            @(negedge clk);
            check(outd[0], {IV[21:6] & m, QV[21:6] & m});
        end
    endtask : t_width
    task automatic t_bypass();
        int n1, n2;
        wb(1'b1, 1, REG_CTRL, 32'h1);
        wb(1'b1, 2, REG_CTRL, 32'h0);
        n1 = err_cnt[1];
        n2 = err_cnt[2];
        agcfe_router_model_inst.send(1, {IV, QV});
        @(negedge clk);
        check(outd[1], {IV[21:6], QV[21:6]});
        agcfe_router_model_inst.send(2, {IV, QV});
        @(negedge clk);
        check(outd[2], {IV[21:18], 12'h0, QV[21:18], 12'h0});
        repeat (5) @(posedge clk);
        check(32'(err_cnt[1] - n1), 32'h0);
        check(32'(err_cnt[2] - n2), 32'h1);
    endtask : t_bypass
    // Power 2^40 is an rms of 20 octaves, 64 steps to the octave
    task automatic t_err();
        put_err(22'h100000, 14'(1344 - 20 * 64));
        wb(1'b1, 0, REG_REQ, 32'h65);
        put_err(22'h100000, 14'(1344 - 101 - 20 * 64));
        rd_chk(0, REG_STATUS, {18'h0, 14'(1344 - 101 - 20 * 64)});
    endtask : t_err
    task automatic t_dec();
        int n;
        wb(1'b1, 0, REG_AVG, 32'h20);
        wb(1'b1, 0, REG_DEC, 32'h3);
        n = err_cnt[0];
        repeat (3) agcfe_router_model_inst.send(0, {22'h100000, 22'h0});
        repeat (4) @(posedge clk);
        check(32'(err_cnt[0] - n), 32'h0);
        put_err(22'h100000, 14'(1344 - 20 * 64));
    endtask : t_dec
    task automatic t_avg();
        wb(1'b1, 0, REG_AVG, 32'h1);
        put_err(22'h100000, 14'(1344 - 20 * 64));
        put_err(22'h100000, 14'(1344 - 41 * 32));
        // Three blocks make 1.5 * 2^41: log 41 plus a linear half octave
        wb(1'b1, 0, REG_AVG, 32'h3);
        put_err(22'h100000, 14'(1344 - (41 * 128 + 64) / 4));
        put_err(22'h100000, 14'(1344 - 21 * 64));
    endtask : t_avg
    // Only the six dropped low bits feed the power in clip mode
    task automatic t_clip();
        wb(1'b1, 0, REG_CTRL, 32'h1e);
        put_err(22'h000020, 14'(1344 - 5 * 64));
    endtask : t_clip
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        cyc  = 1'b0;
        stb  = 1'b0;
        we   = 1'b0;
        adr  = 8'h00;
        sel  = 4'h0;
        wdat = 32'h0;
        do_reset();
        t_regs();
        t_width();
        t_bypass();
        t_err();
        do_reset();
        t_dec();
        do_reset();
        t_avg();
        do_reset();
        t_clip();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
